/* core/pll_lock_detect_pd_control.sv */
// PLL control core: APB registers, dividers, phase comparator, pump gating
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Notes on behaviour
// RL1 - Up-enable bit 5 clear blocks every upward charge_pump pulse.
// RL2 - Down-enable bit 6 clear blocks every downward charge_pump pulse.
// RL3 - Both enables clear: pump high impedance, all else keeps running. Code leaves high impedance off while bit 9 or 10 forces the pump.
// RL4 - Bit 9 forces pump continuously up, bit 10 continuously down.
// RL5 - Reference config bit 21 selects high-frequency buffer, else high gain.
// RL6 - Fourteen-bit reference divider divides by 1 to 16383.
// RL7 - Feedback divider 20..524283 fractional, 16..524287 integer.
// RL8 - Software sets prescaler bit 19 at 4 GHz; feedback then halved.
// RL9 - Lock detection runs only while enable bit 3 is set.
// RL10 - Status bit 1 reads 1 locked, 0 unlocked.
// RL11 - Both edges inside window, either order, increment counter.
// RL12 - Lock declared when counter reaches or exceeds threshold bits 2:0.
// RL13 - Missed window clears counter and reports unlocked at once.
// RL14 - Mode bit 6 low selects fixed 10 ns analog window.
// RL15 - Mode bit 6 high uses speed and divide window fields.
// RL16 - Software uses analog mode only when computed window equals 10 ns.
// RL17 - Software keeps pump offset under 25 percent, up offset only.
// RL18 - Output select enabled with code 1 puts lock on serial pin.
// RL19 - Digital window follows fixed table, 6.5 ns to 338 ns.
// RL20 - Qualification counter saturates at threshold instead of wrapping.
module pll_lock_detect_pd_control
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ref_in,
    input  wire logic        fb_in,
    input  wire logic        serial_read_active,
    input  wire logic        serial_read_data,
    output logic             pump_up,
    output logic             pump_down,
    output logic             pump_hiz,
    output logic             ref_buf_hf,
    output logic             serial_out,
    output logic             serial_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [31:0] cmp_ctrl_q;
    logic [31:0] lock_cfg_q;
    logic [31:0] ref_cfg_q;
    logic [31:0] mode_q;
    logic [31:0] out_sel_q;
    logic [13:0] ref_div_q;
    logic [18:0] fb_div_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    lock_if lk ();

    wire        addr_ok  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    wire [7:0]  idx      = paddr[9:2];
    wire        hit_rdiv = addr_ok && idx == pll_ctl_pkg::IDX_REF_DIV;
    wire        hit_fdiv = addr_ok && idx == pll_ctl_pkg::IDX_FB_DIV;
    wire        hit_mode = addr_ok && idx == pll_ctl_pkg::IDX_MODE;
    wire        hit_lcfg = addr_ok && idx == pll_ctl_pkg::IDX_LOCK_CFG;
    wire        hit_rcfg = addr_ok && idx == pll_ctl_pkg::IDX_REF_CFG;
    wire        hit_cmp  = addr_ok && idx == pll_ctl_pkg::IDX_CMP_CTRL;
    wire        hit_osel = addr_ok && idx == pll_ctl_pkg::IDX_OUT_SEL;
    wire        hit_stat = addr_ok && idx == pll_ctl_pkg::IDX_STATUS;
    wire        mapped   = hit_rdiv | hit_fdiv | hit_mode | hit_lcfg
                         | hit_rcfg | hit_cmp | hit_osel | hit_stat;

    // Answer one cycle into the access phase; commit when pready is seen
    wire        acc_first = psel && penable && !pready_q;
    wire        commit    = psel && penable && pready_q;
    wire        wr_en     = commit && pwrite && !pslverr_q;

    wire [31:0] status_word = {30'h0, lk.locked, 1'b0};            // [RL10]
    wire [31:0] rd_mux =
          hit_rdiv ? {18'h0, ref_div_q}
        : hit_fdiv ? {13'h0, fb_div_q}
        : hit_mode ? mode_q
        : hit_lcfg ? lock_cfg_q
        : hit_rcfg ? ref_cfg_q
        : hit_cmp  ? cmp_ctrl_q
        : hit_osel ? out_sel_q
        : hit_stat ? status_word
        : 32'h0000_0000;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready_q  <= acc_first;
            pslverr_q <= acc_first && (!mapped || (pwrite && hit_stat));
            if (acc_first && !pwrite)
                prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_ctrl_q <= pll_ctl_pkg::RST_CMP_CTRL;
            lock_cfg_q <= pll_ctl_pkg::RST_ZERO;
            ref_cfg_q  <= pll_ctl_pkg::RST_ZERO;
            mode_q     <= pll_ctl_pkg::RST_ZERO;
            out_sel_q  <= pll_ctl_pkg::RST_ZERO;
            ref_div_q  <= pll_ctl_pkg::RST_REF_DIV[13:0];
            fb_div_q   <= pll_ctl_pkg::RST_FB_DIV[18:0];
        end
        else if (ce && wr_en)
        begin
            if (hit_cmp)  cmp_ctrl_q <= pwdata;
            if (hit_lcfg) lock_cfg_q <= pwdata;
            if (hit_rcfg) ref_cfg_q  <= pwdata;
            if (hit_mode) mode_q     <= pwdata;
            if (hit_osel) out_sel_q  <= pwdata;
            if (hit_rdiv) ref_div_q  <= pwdata[13:0];
            if (hit_fdiv) fb_div_q   <= pwdata[18:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge detection, prescaler and dividers
    logic        ref_prev_q;
    logic        fb_prev_q;
    logic        fb_half_q;
    logic [13:0] ref_cnt_q;
    logic [18:0] fb_cnt_q;
    logic        ref_edge_q;
    logic        fb_edge_q;

    wire ref_rise  = ref_in && !ref_prev_q;
    wire fb_rise   = fb_in && !fb_prev_q;
    wire prescale  = ref_cfg_q[pll_ctl_pkg::PRESCALE_BIT];
    wire fb_tick   = prescale ? (fb_rise && fb_half_q) : fb_rise; // [RL8]
    wire frac_mode = mode_q[pll_ctl_pkg::FRAC_EN_BIT];

    wire [13:0] rdiv_eff = (ref_div_q == 14'h0000) ? 14'h0001
                                                   : ref_div_q;   // [RL6]
    wire [18:0] n_min    = frac_mode ? pll_ctl_pkg::N_MIN_FRAC
                                     : pll_ctl_pkg::N_MIN_INT;
    wire [18:0] n_eff    = (fb_div_q < n_min) ? n_min
                         : (frac_mode && fb_div_q > pll_ctl_pkg::N_MAX_FRAC)
                             ? pll_ctl_pkg::N_MAX_FRAC
                             : fb_div_q;                            // [RL7]
    wire ref_tick_last = ref_rise && (ref_cnt_q >= rdiv_eff - 14'h0001);
    wire ref_wrap = ref_tick_last;
    wire fb_wrap  = fb_tick && (fb_cnt_q >= n_eff - 19'h00001);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ref_prev_q <= 1'b0;
            fb_prev_q  <= 1'b0;
            fb_half_q  <= 1'b0;
            ref_cnt_q  <= '0;
            fb_cnt_q   <= '0;
            ref_edge_q <= 1'b0;
            fb_edge_q  <= 1'b0;
        end
        else if (ce)
        begin
            ref_prev_q <= ref_in;
            fb_prev_q  <= fb_in;
            if (fb_rise)
                fb_half_q <= !fb_half_q;
            if (ref_rise)
                ref_cnt_q <= ref_wrap ? '0 : ref_cnt_q + 14'h0001;
            if (fb_tick)
                fb_cnt_q <= fb_wrap ? '0 : fb_cnt_q + 19'h00001;
            ref_edge_q <= ref_wrap;
            fb_edge_q  <= fb_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase comparator and charge_pump gating
    logic cmp_up_q;
    logic cmp_dn_q;
    logic pump_up_q;
    logic pump_down_q;
    logic pump_hiz_q;
    logic ref_buf_hf_q;

    wire up_raw   = cmp_up_q || ref_edge_q;
    wire dn_raw   = cmp_dn_q || fb_edge_q;
    wire both_hi  = up_raw && dn_raw;
    wire up_en    = cmp_ctrl_q[pll_ctl_pkg::UP_EN_BIT];
    wire dn_en    = cmp_ctrl_q[pll_ctl_pkg::DN_EN_BIT];
    wire force_up = cmp_ctrl_q[pll_ctl_pkg::FORCE_UP_BIT];
    wire force_dn = cmp_ctrl_q[pll_ctl_pkg::FORCE_DN_BIT];
    wire up_d     = force_up || (cmp_up_q && up_en);       // [RL1] [RL4]
    wire dn_d     = force_dn || (cmp_dn_q && dn_en);       // [RL2] [RL4]
    wire hiz_d    = !up_en && !dn_en && !force_up && !force_dn; // [RL3]

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_up_q     <= 1'b0;
            cmp_dn_q     <= 1'b0;
            pump_up_q    <= 1'b0;
            pump_down_q  <= 1'b0;
            pump_hiz_q   <= 1'b0;
            ref_buf_hf_q <= 1'b0;
        end
        else if (ce)
        begin
            cmp_up_q     <= up_raw && !both_hi;
            cmp_dn_q     <= dn_raw && !both_hi;
            pump_up_q    <= up_d;
            pump_down_q  <= dn_d;
            pump_hiz_q   <= hiz_d;
            ref_buf_hf_q <= ref_cfg_q[pll_ctl_pkg::REF_BUF_HF_BIT]; // [RL5]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lock detector and serial pin multiplexing
    assign lk.lock_en      = lock_cfg_q[pll_ctl_pkg::LOCK_EN_BIT];
    assign lk.digital_mode = lock_cfg_q[pll_ctl_pkg::LOCK_MODE_BIT];
    assign lk.win_sel      = lock_cfg_q[pll_ctl_pkg::LOCK_WIN_LSB +:
                                        pll_ctl_pkg::LOCK_WIN_W];
    assign lk.threshold    = lock_cfg_q[pll_ctl_pkg::LOCK_THR_LSB +:
                                        pll_ctl_pkg::LOCK_THR_W];
    assign lk.ref_edge     = ref_edge_q;
    assign lk.fb_edge      = fb_edge_q;

    lock_detector u_lock
    (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .lk  (lk.det)
    );

    logic serial_out_q;
    logic serial_oe_q;

    wire show_lock = out_sel_q[pll_ctl_pkg::OUT_SEL_EN_BIT]
        && out_sel_q[pll_ctl_pkg::OUT_SEL_LSB +: pll_ctl_pkg::OUT_SEL_W]
           == pll_ctl_pkg::OUT_SEL_LOCK;
    wire ser_d = serial_read_active ? serial_read_data
                                    : lk.locked;            // [RL18]

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            serial_out_q <= 1'b0;
            serial_oe_q  <= 1'b0;
        end
        else if (ce)
        begin
            serial_out_q <= (show_lock || serial_read_active) && ser_d;
            serial_oe_q  <= show_lock || serial_read_active;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign pump_up    = pump_up_q;
    assign pump_down  = pump_down_q;
    assign pump_hiz   = pump_hiz_q;
    assign ref_buf_hf = ref_buf_hf_q;
    assign serial_out = serial_out_q;
    assign serial_oe  = serial_oe_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_read_status;
        ce && acc_first && !pwrite && hit_stat;
    endsequence

    a_up_masked: assert property ( // [RL1]
        ce && !up_en && !force_up |=> !pump_up_q)
        else $error("up pulse passed while masked");
    a_down_masked: assert property ( // [RL2]
        ce && !dn_en && !force_dn |=> !pump_down_q)
        else $error("down pulse passed while masked");
    a_pump_tristate: assert property ( // [RL3]
        ce && hiz_d |=> pump_hiz_q && !pump_up_q && !pump_down_q)
        else $error("pump not tristated with both enables clear");
    a_force_up: assert property ( // [RL4]
        ce && force_up |=> pump_up_q)
        else $error("forced up not driven");
    a_force_down: assert property ( // [RL4]
        ce && force_dn |=> pump_down_q)
        else $error("forced down not driven");
    a_ref_buf_mode: assert property ( // [RL5]
        ce |=> ref_buf_hf_q
               == $past(ref_cfg_q[pll_ctl_pkg::REF_BUF_HF_BIT]))
        else $error("buffer mode does not follow control bit");
    a_status_lock: assert property ( // [RL10]
        s_read_status |=> prdata_q[1] == $past(lk.locked))
        else $error("status read does not show lock state");
    a_serial_lock: assert property ( // [RL18]
        ce && show_lock && !serial_read_active
            |=> serial_oe_q && serial_out_q == $past(lk.locked))
        else $error("serial pin does not carry lock flag");
    a_apb_answer: assert property ( // APB answer one cycle into the access phase
        ce && acc_first |=> pready_q)
        else $error("no answer one cycle into access");

endmodule // pll_lock_detect_pd_control

/* shared/pll_ctl_pkg.sv */
// Register map, field positions, reset values and timing for the PLL control
package pll_ctl_pkg;

    // Clock and window timing
    localparam int unsigned CLK_PERIOD_PS  = 8000;
    localparam int unsigned ANALOG_WIN_PS  = 10000;
    localparam int unsigned ANALOG_WIN_CYC =
        (ANALOG_WIN_PS / CLK_PERIOD_PS < 1) ? 1
                                            : ANALOG_WIN_PS / CLK_PERIOD_PS;
    localparam int unsigned PS_PER_TENTH_NS = 100;
    localparam int unsigned WIN_CYC_W       = 7;

    // Digital window, tenths of ns, index {speed[1:0], divide[2:0]}
    localparam logic [31:0][15:0] DIG_WIN_TENTHS = {
        16'd3380, 16'd1720, 16'd880, 16'd470,
        16'd260,  16'd154,  16'd102, 16'd76,
        16'd2720, 16'd1380, 16'd720, 16'd380,
        16'd220,  16'd133,  16'd92,  16'd71,
        16'd2550, 16'd1300, 16'd680, 16'd360,
        16'd210,  16'd128,  16'd89,  16'd70,
        16'd1950, 16'd1000, 16'd530, 16'd290,
        16'd170,  16'd110,  16'd80,  16'd65
    };

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_REF_DIV  = 8'h02;
    localparam logic [7:0] IDX_FB_DIV   = 8'h03;
    localparam logic [7:0] IDX_MODE     = 8'h06;
    localparam logic [7:0] IDX_LOCK_CFG = 8'h07;
    localparam logic [7:0] IDX_REF_CFG  = 8'h08;
    localparam logic [7:0] IDX_CMP_CTRL = 8'h0B;
    localparam logic [7:0] IDX_OUT_SEL  = 8'h0F;
    localparam logic [7:0] IDX_STATUS   = 8'h12;
    localparam int unsigned ADDR_W      = 12;

    // Field positions
    localparam int unsigned UP_EN_BIT      = 5;
    localparam int unsigned DN_EN_BIT      = 6;
    localparam int unsigned FORCE_UP_BIT   = 9;
    localparam int unsigned FORCE_DN_BIT   = 10;
    localparam int unsigned PRESCALE_BIT   = 19;
    localparam int unsigned REF_BUF_HF_BIT = 21;
    localparam int unsigned LOCK_THR_LSB   = 0;
    localparam int unsigned LOCK_THR_W     = 3;
    localparam int unsigned LOCK_EN_BIT    = 3;
    localparam int unsigned LOCK_MODE_BIT  = 6;
    localparam int unsigned LOCK_WIN_LSB   = 7;
    localparam int unsigned LOCK_WIN_W     = 5;
    localparam int unsigned FRAC_EN_BIT    = 11;
    localparam int unsigned OUT_SEL_LSB    = 0;
    localparam int unsigned OUT_SEL_W      = 5;
    localparam int unsigned OUT_SEL_EN_BIT = 7;
    localparam int unsigned STATUS_LOCK_BIT = 1;
    localparam logic [4:0]  OUT_SEL_LOCK   = 5'h01;

    // Divider ranges
    localparam int unsigned REF_DIV_W  = 14;
    localparam int unsigned FB_DIV_W   = 19;
    localparam logic [18:0] N_MIN_INT  = 19'h00010;
    localparam logic [18:0] N_MIN_FRAC = 19'h00014;
    localparam logic [18:0] N_MAX_FRAC = 19'h7FFFB;

    // Reset values
    localparam logic [31:0] RST_CMP_CTRL = 32'h0000_0060;
    localparam logic [31:0] RST_REF_DIV  = 32'h0000_0001;
    localparam logic [31:0] RST_FB_DIV   = 32'h0000_0010;
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;

endpackage

/* shared/lock_if.sv */
// Signals between the control core and the lock detector
`timescale 1ns/100ps
interface lock_if;
    logic       lock_en;
    logic       digital_mode;
    logic [4:0] win_sel;
    logic [2:0] threshold;
    logic       ref_edge;
    logic       fb_edge;
    logic       locked;

    modport ctl (output lock_en, digital_mode, win_sel, threshold,
                 ref_edge, fb_edge, input locked);
    modport det (input lock_en, digital_mode, win_sel, threshold,
                 ref_edge, fb_edge, output locked);
endinterface

/* core/lock_detector.sv */
// Window-qualified lock detector with saturating qualification counter
`timescale 1ns/100ps
module lock_detector
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    lock_if.det       lk
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {IDLE, WAIT_FB, WAIT_REF} ld_state_t;

    ld_state_t                                 state_q;
    logic      [pll_ctl_pkg::WIN_CYC_W-1:0]    timer_q;
    logic      [2:0]                           cnt_q;
    logic                                      locked_q;
    logic      [pll_ctl_pkg::WIN_CYC_W-1:0]    dig_cyc [32];

    // Digital window lengths in clock cycles, floored, at least one
    for (genvar i = 0; i < 32; i++)
    begin : g_win
        localparam int unsigned CYC = int'(pll_ctl_pkg::DIG_WIN_TENTHS[i])
            * pll_ctl_pkg::PS_PER_TENTH_NS / pll_ctl_pkg::CLK_PERIOD_PS;
        assign dig_cyc[i] = (CYC < 1) ? pll_ctl_pkg::WIN_CYC_W'(1)
                                      : pll_ctl_pkg::WIN_CYC_W'(CYC); // [RL19]
    end

    wire [pll_ctl_pkg::WIN_CYC_W-1:0] win_cyc = lk.digital_mode
        ? dig_cyc[lk.win_sel]                                    // [RL15]
        : pll_ctl_pkg::WIN_CYC_W'(pll_ctl_pkg::ANALOG_WIN_CYC);  // [RL14]
    wire [pll_ctl_pkg::WIN_CYC_W-1:0] elapsed = timer_q + 1'b1;
    wire waiting   = (state_q != IDLE);
    wire partner   = (state_q == WAIT_FB) ? lk.fb_edge : lk.ref_edge;
    wire both_now  = (state_q == IDLE) && lk.ref_edge && lk.fb_edge;
    // Either edge may lead; only the gap between them counts
    wire qualify   = both_now
                   || (waiting && partner && elapsed <= win_cyc);  // [RL11]
    wire fail      = waiting && !partner && elapsed >= win_cyc;    // [RL13]
    wire at_thr    = (cnt_q >= lk.threshold);
    wire [2:0] cnt_d = at_thr ? cnt_q : cnt_q + 3'h1;              // [RL20]

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= IDLE;
            timer_q <= '0;
        end
        else if (ce)
        begin
            timer_q <= waiting ? elapsed : '0;
            if (!lk.lock_en || qualify || fail)
                state_q <= IDLE;
            else if (state_q == IDLE && lk.ref_edge)
                state_q <= WAIT_FB;
            else if (state_q == IDLE && lk.fb_edge)
                state_q <= WAIT_REF;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q    <= '0;
            locked_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!lk.lock_en || fail)
            begin
                cnt_q    <= '0;                                   // [RL9] [RL13]
                locked_q <= 1'b0;
            end
            else if (qualify)
            begin
                cnt_q    <= cnt_d;                                // [RL11]
                locked_q <= (cnt_d >= lk.threshold);              // [RL12]
            end
        end
    end

    assign lk.locked = locked_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_miss;
        ce && fail;
    endsequence

    a_miss_unlocks: assert property ( // [RL13]
        s_miss |=> !locked_q && cnt_q == 3'h0)
        else $error("missed window did not clear lock");
    a_disable_unlock: assert property ( // [RL9]
        ce && !lk.lock_en |=> !locked_q)
        else $error("lock reported while detection disabled");
    a_lock_at_thr: assert property ( // [RL12]
        $rose(locked_q) |-> cnt_q >= $past(lk.threshold))
        else $error("lock rose below threshold");
    a_count_qualify: assert property ( // [RL11]
        ce && lk.lock_en && qualify && !at_thr
            |=> cnt_q == $past(cnt_q) + 3'h1)
        else $error("qualified edge pair not counted");

endmodule // lock_detector

/* testbench/pll_edge_source.sv */
// Reference and feedback edge source facing the PLL control core
`timescale 1ns/100ps
module pll_edge_source
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic fb_run,
    output logic      ref_in,
    output logic      fb_in
);
    logic [4:0] ref_cnt_q;

    // Reference rises once in 32 cycles; feedback rises every second cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ref_cnt_q <= 5'h00;
            fb_in     <= 1'b0;
        end
        else
        begin
            ref_cnt_q <= ref_cnt_q + 5'h01;
            fb_in     <= fb_run & ~fb_in;
        end
    end
    assign ref_in = (ref_cnt_q == 5'h1F);
endmodule // pll_edge_source

/* testbench/pll_lock_detect_pd_control_bench.sv */
// Self-checking bench for the PLL control core
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module pll_lock_detect_pd_control_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        rd_act = 1'b0;
    logic        rd_dat = 1'b0;
    logic        fb_run = 1'b1;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, rerr, ref_in, fb_in;
    logic        pump_up, pump_down, pump_hiz, ref_buf_hf;
    logic        serial_out, serial_oe;
    logic [2:0]  pv;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    assign pv = {pump_up, pump_down, pump_hiz};
    always #4 clk = ~clk;

    pll_lock_detect_pd_control dut (.clk(clk), .rst(rst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_in(ref_in), .fb_in(fb_in),
        .serial_read_active(rd_act), .serial_read_data(rd_dat),
        .pump_up(pump_up), .pump_down(pump_down), .pump_hiz(pump_hiz),
        .ref_buf_hf(ref_buf_hf), .serial_out(serial_out),
        .serial_oe(serial_oe));
    pll_edge_source src (.clk(clk), .rst(rst), .fb_run(fb_run),
        .ref_in(ref_in), .fb_in(fb_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            print_verdict();
        end
    end

    // One APB transfer; read data and error land in rdat and rerr
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(1'b0, pll_ctl_pkg::IDX_CMP_CTRL, 32'h0);
        `CHK(rdat, pll_ctl_pkg::RST_CMP_CTRL)
        apb(1'b0, pll_ctl_pkg::IDX_FB_DIV, 32'h0);
        `CHK(rdat, pll_ctl_pkg::RST_FB_DIV)
        apb(1'b0, pll_ctl_pkg::IDX_STATUS, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b1, pll_ctl_pkg::IDX_STATUS, 32'hFFFFFFFF);
        `CHK(rerr, 1'b1)
        apb(1'b0, 8'h01, 32'h0);
        `CHK({rerr, rdat}, {1'b1, 32'h0})
        // All ones into the divider keeps only its 14 bits
        apb(1'b1, pll_ctl_pkg::IDX_REF_DIV, 32'hFFFFFFFF);
        apb(1'b0, pll_ctl_pkg::IDX_REF_DIV, 32'h0);
        `CHK(rdat, 32'h00003FFF)
        apb(1'b1, pll_ctl_pkg::IDX_REF_DIV, pll_ctl_pkg::RST_REF_DIV);
    endtask

    task automatic t_pump();
        logic [31:0] cfg [6] = '{32'h0, 32'h20, 32'h40, 32'h200, 32'h400,
                                 32'h600};
        logic [2:0]  msk [6] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h6};
        logic [2:0]  val [6] = '{3'h1, 3'h0, 3'h0, 3'h4, 3'h2, 3'h6};
        // Pump offset currents are never programmed here
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, pll_ctl_pkg::IDX_CMP_CTRL, cfg[i]);
            repeat (3) @(posedge clk);
            repeat (64)
            begin
                @(posedge clk);
                `CHK(pv & msk[i], val[i])
            end
        end
    endtask

    // Clock enable low stalls the transfer; it completes once enabled
    task automatic t_buf();
        ce <= 1'b0;
        fork
            apb(1'b1, pll_ctl_pkg::IDX_REF_CFG, 32'h00200000);
            begin
                repeat (6) @(posedge clk);
                `CHK({pready, ref_buf_hf}, 2'h0)
                ce <= 1'b1;
            end
        join
        @(posedge clk);
        `CHK(ref_buf_hf, 1'b1)
        apb(1'b1, pll_ctl_pkg::IDX_REF_CFG, 32'h0);
        @(posedge clk);
        `CHK(ref_buf_hf, 1'b0)
    endtask

    // Poll the status word until lock reads as expected
    task automatic wait_lock(input logic exp);
        int n;
        n = 0;
        do
            apb(1'b0, pll_ctl_pkg::IDX_STATUS, 32'h0);
        while (rdat[1] !== exp && ++n < 120);
    endtask

    task automatic t_lock();
        apb(1'b1, pll_ctl_pkg::IDX_CMP_CTRL, 32'h0);
        apb(1'b1, pll_ctl_pkg::IDX_OUT_SEL, 32'h81);
        // Divided edges coincide here, so the fixed window fits
        apb(1'b1, pll_ctl_pkg::IDX_LOCK_CFG, 32'hA);
        wait_lock(1'b1);
        `CHK(rdat[1], 1'b1)
        // Slowest digital window, threshold 2, detection switched off
        apb(1'b1, pll_ctl_pkg::IDX_LOCK_CFG, 32'hFC2);
        repeat (200) @(posedge clk);
        apb(1'b0, pll_ctl_pkg::IDX_STATUS, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b1, pll_ctl_pkg::IDX_LOCK_CFG, 32'hFCA);
        wait_lock(1'b1);
        `CHK(rdat, 32'h2)
        `CHK({serial_oe, serial_out}, 2'h3)
        rd_act <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(serial_out, 1'b0)
        rd_act <= 1'b0;
        fb_run <= 1'b0;
        wait_lock(1'b0);
        `CHK(rdat[1], 1'b0)
        repeat (2) @(posedge clk);
        `CHK(serial_out, 1'b0)
        fb_run <= 1'b1;
        wait_lock(1'b1);
        `CHK(rdat[1], 1'b1)
        // Halved feedback against a reference divided by two
        apb(1'b1, pll_ctl_pkg::IDX_LOCK_CFG, 32'hFC2);
        apb(1'b1, pll_ctl_pkg::IDX_REF_DIV, 32'h2);
        apb(1'b1, pll_ctl_pkg::IDX_REF_CFG, 32'h00080000);
        apb(1'b1, pll_ctl_pkg::IDX_LOCK_CFG, 32'hFCA);
        wait_lock(1'b1);
        `CHK(rdat[1], 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_pump();
        t_lock();
        t_buf();
        print_verdict();
    end
endmodule // pll_lock_detect_pd_control_bench
